// file: pkg/codec_ctrl_pkg.sv
// Constants shared by the voice codec host control logic
package codec_ctrl_pkg;

	// ------------------------------------------------------------------
	// Select codes, written as {reg_select_hi, reg_select_lo}
	// ------------------------------------------------------------------
	localparam logic [1:0] SEL_PRIMARY   = 2'h0; // rate ctrl / flags
	localparam logic [1:0] SEL_SECONDARY = 2'h1; // page ctrl / levels
	localparam logic [1:0] SEL_DATA      = 2'h2; // decode / encode data
	localparam logic [1:0] SEL_NONE      = 2'h3; // nothing mapped

	// ------------------------------------------------------------------
	// Field positions in rate_filter_control
	// ------------------------------------------------------------------
	localparam int IRA_ENC_IDLE = 0;
	localparam int IRA_DEC_SRC  = 1;
	localparam int IRA_DEC_RATE = 2;
	localparam int IRA_DEC_FILT = 3;
	localparam int IRA_DEC_MSTR = 4;
	localparam int IRA_ENC_RATE = 5;
	localparam int IRA_ENC_FILT = 6;
	localparam int IRA_ENC_MSTR = 7;

	// Field positions in page_input_control
	localparam int IRB_PAGE_LSB  = 0;
	localparam int IRB_PAGE_MSB  = 2;
	localparam int IRB_INPUT_SEL = 3;

	// Field positions in flag_register
	localparam int SR_ENC_RDY  = 0;
	localparam int SR_DEC_RDY  = 1;
	localparam int SR_PAGE_RDY = 2;
	localparam int SR_ENC_OVF  = 3;
	localparam int SR_DEC_OVF  = 4;
	localparam int SR_PAGE_OVF = 5;

	// Values after reset
	localparam logic [7:0] RATE_FILTER_RESET = 8'h00;
	localparam logic [7:0] PAGE_INPUT_RESET  = 8'h00;

	// ------------------------------------------------------------------
	// Divider ratios and byte framing
	// ------------------------------------------------------------------
	localparam logic [3:0] MSTR_DIV_HI = 4'ha;
	localparam logic [3:0] MSTR_DIV_LO = 4'h8;
	localparam logic [1:0] FILT_DIV_HI = 2'h2;
	localparam logic [1:0] FILT_DIV_LO = 2'h1;
	localparam logic [3:0] RATE_DIV_HI = 4'h8;
	localparam logic [3:0] RATE_DIV_LO = 4'h4;
	localparam logic [2:0] LAST_BIT    = 3'h7;

	// ------------------------------------------------------------------
	// Access timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 8;
	localparam int MIN_SELECT_NS   = 100; // plain default
	localparam int MIN_SELECT_INT  =
		(MIN_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] MIN_SELECT_CYC = MIN_SELECT_INT[7:0];

endpackage

// file: src/voice_codec_host_control.sv
// Host port, dividers and byte framing of the voice codec
//
// Behaviour
// - Writes routed by select lines to registers
// - Reads return register picked by select lines
// - Wait held until minimum select time passes
// - Interrupt pin only ever pulls low
// - Encoder idle fills register with 1010 pattern
// - Encoded bytes move to buffer on last bit
// - Decoder source feeds encoder output into decoder
// - Decode overspill fills decoder with idle pattern
// - Host decode write always overwrites decode register
// - Decode rate divider eight or four
// - Decode filter divider two or one
// - Decode master divider ten or eight
// - Encode rate divider eight or four
// - Encode filter divider two or one
// - Encode master divider ten or eight
// - Filter and bit clocks from cascaded dividers
// - Page holds thirty-two times field plus one
// - Input select bit picks audio A or B
// - Encode ready set on last bit, interrupts
// - Unserviced ready becomes overspill, buffer frozen
// - Decode overspill blocks decode ready, fills idle
`timescale 1ns/1ps
`default_nettype none

module voice_codec_host_control (
	input  wire logic                sys_clk_i,
	input  wire logic                resetn_i,
	input  wire logic                clk_en_i,
	input  wire logic                reg_select_lo_i,
	input  wire logic                reg_select_hi_i,
	input  wire logic                read_not_write_i,
	input  wire logic                chip_select_n_i,
	input  wire logic [7:0]          data_i,
	output logic      [7:0]          data_o,
	output logic                     data_oe_o,
	output logic                     wait_n_o,
	output logic                     wait_oe_o,
	output logic                     irq_n_o,
	output logic                     irq_oe_o,
	input  wire logic                master_clk_i,
	input  wire logic                enc_bit_i,
	input  wire logic [7:0]          level_i,
	output logic                     dec_bit_o,
	output logic      [1:0]          filter_tick_o,
	output logic      [1:0]          bit_tick_o,
	output logic                     input_b_select_o
);
	import codec_ctrl_pkg::*;

	// ------------------------------------------------------------------
	// State; index 0 of per-direction fields is encode, 1 is decode
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]      rate_filter_control;
		logic [7:0]      page_input_control;
		logic [7:0]      sel_cnt;
		logic            acc_done;
		logic            mclk_prev;
		logic [1:0][3:0] mstr_cnt;
		logic [1:0][1:0] filt_cnt;
		logic [1:0][3:0] rate_cnt;
		logic [1:0]      filt_tick;
		logic [1:0]      bit_tick;
		logic [7:0]      enc_sr;
		logic [7:0]      enc_buf;
		logic [2:0]      enc_cnt;
		logic            idle_phase;
		logic [7:0]      dec_sr;
		logic [2:0]      dec_cnt;
		logic            dec_bit;
		logic [5:0]      flag_register;
		logic [8:0]      page_cnt;
		logic [7:0]      level_register;
		logic [7:0]      rd_data;
	} state_t;

	state_t      st_ff;
	state_t      nxt_st;
	logic [1:0]  sel;
	logic        acc_fire;
	logic [7:0]  rd_mux;
	logic [8:0]  page_bytes;
	logic [1:0]  mstr_sel;
	logic [1:0]  filt_sel;
	logic [1:0]  rate_sel;

	// ------------------------------------------------------------------
	// Host port decode
	// ------------------------------------------------------------------
	assign sel = {reg_select_hi_i, reg_select_lo_i};

	// access fires once the minimum select time has run
	assign acc_fire = !chip_select_n_i && !st_ff.acc_done &&
		(st_ff.sel_cnt == MIN_SELECT_CYC - 8'h01);

	// Per-direction divider selects, encode in bit 0
	assign mstr_sel = {st_ff.rate_filter_control[IRA_DEC_MSTR],
		st_ff.rate_filter_control[IRA_ENC_MSTR]};
	assign filt_sel = {st_ff.rate_filter_control[IRA_DEC_FILT],
		st_ff.rate_filter_control[IRA_ENC_FILT]};
	assign rate_sel = {st_ff.rate_filter_control[IRA_DEC_RATE],
		st_ff.rate_filter_control[IRA_ENC_RATE]};

	// page length in bytes, 32 up to 256
	assign page_bytes = {({1'b0, st_ff.page_input_control[
		IRB_PAGE_MSB:IRB_PAGE_LSB]} + 4'h1), 5'h00};

	always_comb begin
		case (sel)
			SEL_PRIMARY:   rd_mux = {2'h0, st_ff.flag_register};
			SEL_SECONDARY: rd_mux = st_ff.level_register;
			SEL_DATA:      rd_mux = st_ff.enc_buf;
			default:       rd_mux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [7:0] new_byte;
		logic       in_bit;
		logic       mtick;
		logic [3:0] n1;
		logic [1:0] n2;
		logic [3:0] n3;
		new_byte = 8'h00;
		in_bit   = 1'b0;
		mtick    = 1'b0;
		n1       = 4'h0;
		n2       = 2'h0;
		n3       = 4'h0;
		nxt_st   = st_ff;

		// Select timer; one action per chip-select assertion
		if (chip_select_n_i) begin
			nxt_st.sel_cnt  = 8'h00;
			nxt_st.acc_done = 1'b0;
		end else if (!st_ff.acc_done) begin
			nxt_st.sel_cnt = st_ff.sel_cnt + 8'h01;
			nxt_st.rd_data = rd_mux; // Frozen once the access fires
			if (acc_fire)
				nxt_st.acc_done = 1'b1;
		end

		// Host actions come first so hardware sets below win
		if (acc_fire && !read_not_write_i) begin
			case (sel)
				SEL_PRIMARY: nxt_st.rate_filter_control = data_i;
				SEL_SECONDARY: begin
					nxt_st.page_input_control         = data_i;
					nxt_st.flag_register[SR_PAGE_OVF] = 1'b0;
				end
				SEL_DATA: begin
					nxt_st.dec_sr                    = data_i;
					nxt_st.dec_cnt                   = 3'h0;
					nxt_st.flag_register[SR_DEC_RDY] = 1'b0;
					if (st_ff.flag_register[SR_ENC_OVF] &&
						st_ff.flag_register[SR_DEC_OVF]) begin
						nxt_st.flag_register[SR_ENC_OVF] = 1'b0;
						nxt_st.flag_register[SR_DEC_OVF] = 1'b0;
						nxt_st.enc_cnt                   = 3'h0;
					end
				end
				default: nxt_st.sel_cnt = nxt_st.sel_cnt;
			endcase
		end else if (acc_fire) begin
			case (sel)
				SEL_SECONDARY: begin
					nxt_st.flag_register[SR_PAGE_RDY] = 1'b0;
					nxt_st.flag_register[SR_PAGE_OVF] = 1'b0;
				end
				SEL_DATA: begin
					nxt_st.flag_register[SR_ENC_RDY] = 1'b0;
					if (st_ff.flag_register[SR_ENC_OVF] &&
						st_ff.flag_register[SR_DEC_OVF]) begin
						nxt_st.flag_register[SR_ENC_OVF] = 1'b0;
						nxt_st.flag_register[SR_DEC_OVF] = 1'b0;
						nxt_st.enc_cnt                   = 3'h0;
						nxt_st.dec_cnt                   = 3'h0;
					end
				end
				default: nxt_st.rd_data = nxt_st.rd_data;
			endcase
		end

		// cascaded dividers on master clock rising edges
		nxt_st.mclk_prev = master_clk_i;
		mtick            = master_clk_i && !st_ff.mclk_prev;
		nxt_st.filt_tick = 2'h0;
		nxt_st.bit_tick  = 2'h0;
		for (int d = 0; d < 2; d++) begin
			n1 = mstr_sel[d] ? MSTR_DIV_HI : MSTR_DIV_LO;
			n2 = filt_sel[d] ? FILT_DIV_HI : FILT_DIV_LO;
			n3 = rate_sel[d] ? RATE_DIV_HI : RATE_DIV_LO;
			if (mtick) begin
				if (st_ff.mstr_cnt[d] >= n1 - 4'h1) begin
					nxt_st.mstr_cnt[d] = 4'h0;
					if (st_ff.filt_cnt[d] >= n2 - 2'h1) begin
						nxt_st.filt_cnt[d]  = 2'h0;
						nxt_st.filt_tick[d] = 1'b1;
					end else begin
						nxt_st.filt_cnt[d] = st_ff.filt_cnt[d] + 2'h1;
					end
					if (st_ff.rate_cnt[d] >= n3 - 4'h1) begin
						nxt_st.rate_cnt[d] = 4'h0;
						nxt_st.bit_tick[d] = 1'b1;
					end else begin
						nxt_st.rate_cnt[d] = st_ff.rate_cnt[d] + 4'h1;
					end
				end else begin
					nxt_st.mstr_cnt[d] = st_ff.mstr_cnt[d] + 4'h1;
				end
			end
		end

		// Encode side, stepped on the registered bit tick
		if (st_ff.bit_tick[0]) begin
			nxt_st.idle_phase = !st_ff.idle_phase;
			in_bit = st_ff.rate_filter_control[IRA_ENC_IDLE] ?
				st_ff.idle_phase : enc_bit_i;
			new_byte       = {st_ff.enc_sr[6:0], in_bit};
			nxt_st.enc_sr  = new_byte;
			nxt_st.enc_cnt = nxt_st.enc_cnt + 3'h1;
			if (st_ff.enc_cnt == LAST_BIT) begin
				if (nxt_st.flag_register[SR_ENC_RDY]) begin
					nxt_st.flag_register[SR_ENC_RDY] = 1'b0;
					nxt_st.flag_register[SR_ENC_OVF] = 1'b1;
				end else if (!nxt_st.flag_register[SR_ENC_OVF]) begin
					nxt_st.enc_buf                   = new_byte;
					nxt_st.flag_register[SR_ENC_RDY] = 1'b1;
				end
				if (st_ff.page_cnt + 9'h001 >= page_bytes) begin
					nxt_st.page_cnt       = 9'h000;
					nxt_st.level_register = level_i;
					if (nxt_st.flag_register[SR_PAGE_RDY]) begin
						nxt_st.flag_register[SR_PAGE_RDY] = 1'b0;
						nxt_st.flag_register[SR_PAGE_OVF] = 1'b1;
					end else if (!nxt_st.flag_register[SR_PAGE_OVF]) begin
						nxt_st.flag_register[SR_PAGE_RDY] = 1'b1;
					end
				end else begin
					nxt_st.page_cnt = st_ff.page_cnt + 9'h001;
				end
			end
		end

		// Decode side, MSB first
		if (st_ff.bit_tick[1]) begin
			nxt_st.dec_bit = nxt_st.dec_sr[7];
			in_bit = st_ff.rate_filter_control[IRA_DEC_SRC] ?
				st_ff.enc_sr[7] : st_ff.idle_phase;
			nxt_st.dec_sr  = {nxt_st.dec_sr[6:0], in_bit};
			nxt_st.dec_cnt = nxt_st.dec_cnt + 3'h1;
			if (nxt_st.dec_cnt == 3'h0) begin
				if (nxt_st.flag_register[SR_DEC_RDY]) begin
					nxt_st.flag_register[SR_DEC_RDY] = 1'b0;
					nxt_st.flag_register[SR_DEC_OVF] = 1'b1;
				end else if (!nxt_st.flag_register[SR_DEC_OVF]) begin
					nxt_st.flag_register[SR_DEC_RDY] = 1'b1;
				end
			end
		end

		if (!clk_en_i)
			nxt_st = st_ff;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_ff                     <= '0;
			st_ff.rate_filter_control <= RATE_FILTER_RESET;
			st_ff.page_input_control  <= PAGE_INPUT_RESET;
			st_ff.idle_phase          <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign data_o    = st_ff.rd_data;
	// unmapped read leaves the bus undriven
	assign data_oe_o = !chip_select_n_i && read_not_write_i &&
		(sel != SEL_NONE);
	// wait pulled low while the access is pending
	assign wait_n_o  = 1'b0;
	assign wait_oe_o = !chip_select_n_i && !st_ff.acc_done;
	// open-drain, drives only low; overspill drops ready
	assign irq_n_o   = 1'b0;
	assign irq_oe_o  = st_ff.flag_register[SR_ENC_RDY] ||
		st_ff.flag_register[SR_DEC_RDY] ||
		st_ff.flag_register[SR_PAGE_RDY];
	assign dec_bit_o     = st_ff.dec_bit;
	assign filter_tick_o = st_ff.filt_tick;
	assign bit_tick_o    = st_ff.bit_tick;
	assign input_b_select_o = st_ff.page_input_control[IRB_INPUT_SEL];

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i || !clk_en_i);

	a_wait_hold: assert property ($rose(wait_oe_o) |->
		(wait_oe_o || chip_select_n_i) [*8])
		else $error("wait released before minimum select time");
	a_wait_ends: assert property (acc_fire |=> !wait_oe_o)
		else $error("wait still asserted after access");
	a_write_rate: assert property (acc_fire && !read_not_write_i &&
		sel == SEL_PRIMARY |=>
		st_ff.rate_filter_control == $past(data_i))
		else $error("rate control write lost");
	a_unmapped_quiet: assert property (acc_fire && sel == SEL_NONE &&
		!st_ff.bit_tick[0] && !st_ff.bit_tick[1] |=>
		$stable(st_ff.flag_register) &&
		$stable(st_ff.rate_filter_control))
		else $error("unmapped access changed state");
	a_read_status: assert property (!chip_select_n_i && read_not_write_i
		&& !st_ff.acc_done && sel == SEL_PRIMARY |=>
		data_o == {2'h0, $past(st_ff.flag_register)})
		else $error("status read mismatch");
	a_idle_pattern: assert property (st_ff.bit_tick[0] &&
		st_ff.rate_filter_control[IRA_ENC_IDLE] |=>
		st_ff.enc_sr[0] == $past(st_ff.idle_phase))
		else $error("idle pattern not filled");
	a_enc_ready: assert property (st_ff.bit_tick[0] &&
		st_ff.enc_cnt == LAST_BIT &&
		!st_ff.flag_register[SR_ENC_RDY] &&
		!st_ff.flag_register[SR_ENC_OVF] |=>
		st_ff.flag_register[SR_ENC_RDY] ##0 irq_oe_o)
		else $error("encode ready not raised");
	a_enc_overspill: assert property (st_ff.bit_tick[0] &&
		st_ff.enc_cnt == LAST_BIT &&
		st_ff.flag_register[SR_ENC_RDY] && !acc_fire |=>
		st_ff.flag_register[SR_ENC_OVF] &&
		!st_ff.flag_register[SR_ENC_RDY] &&
		$stable(st_ff.enc_buf))
		else $error("encode overspill not flagged");
	a_dec_load: assert property (acc_fire && !read_not_write_i &&
		sel == SEL_DATA && !st_ff.bit_tick[1] |=>
		st_ff.dec_sr == $past(data_i))
		else $error("decode write not loaded");
	a_irq_open_drain: assert property (irq_n_o == 1'b0 &&
		wait_n_o == 1'b0)
		else $error("open-drain pin driven high");

	c_host_write: cover property (acc_fire && !read_not_write_i &&
		sel == SEL_DATA);
	c_enc_read: cover property (acc_fire && read_not_write_i &&
		sel == SEL_DATA && st_ff.flag_register[SR_ENC_RDY]);
	c_enc_ovf: cover property ($rose(st_ff.flag_register[SR_ENC_OVF]));
	c_page_done: cover property ($rose(st_ff.flag_register[SR_PAGE_RDY]));

endmodule

`default_nettype wire

// file: test/host_bus_model.sv
// Host processor model driving the codec's parallel port
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
	input  wire logic       sys_clk_i,
	input  wire logic       wait_oe_i,
	input  wire logic       data_oe_i,
	input  wire logic [7:0] rd_data_i,
	output logic            cs_n_o,
	output logic            sel_lo_o,
	output logic            sel_hi_o,
	output logic            rnw_o,
	output logic [7:0]      wr_data_o
);
	int   wait_cnt;
	logic oe_seen;

	// Bus idles deselected; released data lines never hold a stale value
	initial begin
		cs_n_o    = 1'b1;
		sel_lo_o  = 1'b0;
		sel_hi_o  = 1'b0;
		rnw_o     = 1'b1;
		wr_data_o = 8'h5a;
	end

	task automatic access(input logic [1:0] sel, input logic rnw,
		input logic [7:0] wd, input int extra,
		output logic [7:0] rd, output logic ok);
		int i;
		ok       = 1'b0;
		wait_cnt = 0;
		oe_seen  = 1'b0;
		@(posedge sys_clk_i);
		cs_n_o    <= 1'b0;
		sel_hi_o  <= sel[1];
		sel_lo_o  <= sel[0];
		rnw_o     <= rnw;
		wr_data_o <= rnw ? ~wr_data_o : wd;
		// Looked at mid-cycle; settled until the next rising edge
		for (i = 0; i < 64 && !ok; i++) begin
			@(negedge sys_clk_i);
			oe_seen = oe_seen | (data_oe_i === 1'b1);
			if (wait_oe_i === 1'b0)
				ok = 1'b1;
			else
				wait_cnt++;
		end
		rd = rd_data_i;
		// Slow host keeps select low a little longer
		repeat (extra) @(posedge sys_clk_i);
		@(posedge sys_clk_i);
		cs_n_o    <= 1'b1;
		wr_data_o <= ~wr_data_o;
	endtask
endmodule
`default_nettype wire

// file: test/voice_codec_host_control_tb_top.sv
// Self-checking bench for the codec host port, dividers and framing
`timescale 1ns/1ps
`default_nettype none

module voice_codec_host_control_tb_top;
	import codec_ctrl_pkg::*;

	localparam int MPER = 4; // master period in system cycles
	logic        sys_clk, resetn, mclk, enc_bit, cs_n, sel_lo, sel_hi;
	logic        rnw, oe, wt_n, wt_oe, irq_n, irq_oe, dec_bit, in_b, ok;
	logic        tick_seen, wprev, clk_en;
	logic [7:0]  wdata, rdata, level, rd, v;
	logic [1:0]  ftk, btk, mc;
	logic [3:0]  tks;
	logic [15:0] rx;
	int          num_errors, check_count, nbits, i, k, gap[4], cnt[4];

	assign tks  = {btk, ftk};
	assign mclk = mc[1];

	voice_codec_host_control uut (
		.sys_clk_i(sys_clk), .resetn_i(resetn), .clk_en_i(clk_en),
		.reg_select_lo_i(sel_lo), .reg_select_hi_i(sel_hi),
		.read_not_write_i(rnw), .chip_select_n_i(cs_n),
		.data_i(wdata), .data_o(rdata), .data_oe_o(oe),
		.wait_n_o(wt_n), .wait_oe_o(wt_oe), .irq_n_o(irq_n),
		.irq_oe_o(irq_oe), .master_clk_i(mclk), .enc_bit_i(enc_bit),
		.level_i(level), .dec_bit_o(dec_bit), .filter_tick_o(ftk),
		.bit_tick_o(btk), .input_b_select_o(in_b));

	host_bus_model host (
		.sys_clk_i(sys_clk), .wait_oe_i(wt_oe), .data_oe_i(oe),
		.rd_data_i(rdata), .cs_n_o(cs_n), .sel_lo_o(sel_lo),
		.sel_hi_o(sel_hi), .rnw_o(rnw), .wr_data_o(wdata));

	// ----------------------------------------------------------------
	// Clocks and monitors
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// master clock, faster than 1 MHz so pages stay short
	always @(posedge sys_clk) mc <= mc + 2'h1;

	// Tick gaps and decoder bits; capture restarts when a data or unmapped write lands
	always @(negedge sys_clk) begin
		for (int t = 0; t < 4; t++) begin
			cnt[t]++;
			if (tks[t] === 1'b1) begin
				gap[t] = cnt[t];
				cnt[t] = 0;
			end
		end
		if (wt_oe === 1'b0 && wprev && sel_hi && !rnw) nbits = 0;
		wprev = (wt_oe === 1'b1);
		if (tick_seen) begin
			rx = {rx[14:0], dec_bit};
			nbits++;
		end
		tick_seen = (btk[1] === 1'b1);
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic err(input string s);
		num_errors++;
		$display("mismatch at %0t: %s", $time, s);
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) err($sformatf("got %h expected %h", g, e));
	endtask

	task automatic chk_int(input int g, input int e);
		check_count++;
		if (g != e) err($sformatf("got %0d expected %0d", g, e));
	endtask

	task automatic results();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic acc(input logic [1:0] s, input logic r,
		input logic [7:0] d);
		host.access(s, r, d, $urandom_range(2), rd, ok);
		if (!ok) begin
			err("wait never released");
			results();
		end
	endtask

	// Poll the flags until every bit of the mask is set
	task automatic wait_flag(input logic [7:0] m);
		int n;
		for (n = 0; n < 3000; n++) begin
			acc(SEL_PRIMARY, 1'b1, 8'h00);
			if ((rd & m) === m) break;
		end
		if (n == 3000) begin
			err("flag never set");
			results();
		end
	endtask

	task automatic dec_cap(input logic [7:0] b);
		int n;
		acc(SEL_DATA, 1'b0, b);
		for (n = 0; n < 6000 && nbits < 16; n++) @(posedge sys_clk);
		if (nbits < 16) begin
			err("decoder bits missing");
			results();
		end
	endtask

	// Gap in cycles of tick t: 0/1 filter enc/dec, 2/3 bit enc/dec
	function automatic int exp_gap(logic [7:0] c, int t);
		int b;
		int m;
		b = (t % 2) ? IRA_DEC_RATE : IRA_ENC_RATE;
		m = (c[b + 2] ? 10 : 8) * MPER;
		if (t < 2) return m * (c[b + 1] ? 2 : 1);
		return m * (c[b] ? 8 : 4);
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h2825));
		resetn = 1'b0;
		clk_en = 1'b1;
		enc_bit = 1'b1;
		level = $urandom;
		mc = 2'h0;
		rx = 16'h0;
		nbits = 0;
		tick_seen = 1'b0;
		wprev = 1'b0;
		num_errors = 0;
		check_count = 0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		chk8({6'h0, irq_n, wt_n}, 8'h00);
		acc(SEL_PRIMARY, 1'b1, 8'h00);
		chk8(rd, 8'h00);
		chk_int(host.wait_cnt, MIN_SELECT_INT);
		chk8({7'h0, host.oe_seen}, 8'h01);
		// Page field kept at zero so the page test stays short
		for (i = 0; i < 4; i++) begin
			v = ($urandom & 8'hf0) | {4'h0, i[0], 3'h0};
			acc(SEL_SECONDARY, 1'b0, v);
			chk8({7'h0, in_b}, {7'h0, v[3]});
			acc(SEL_NONE, 1'b0, ~v);
			chk8({7'h0, in_b}, {7'h0, v[3]});
			acc(SEL_NONE, 1'b1, 8'h00);
			chk8({7'h0, host.oe_seen}, 8'h00);
		end
		for (i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hfc : $urandom;
			acc(SEL_PRIMARY, 1'b0, v);
			repeat (1400) @(posedge sys_clk);
			chk_int(gap[0], exp_gap(v, 0));
			chk_int(gap[1], exp_gap(v, 1));
			chk_int(gap[2], exp_gap(v, 2));
			chk_int(gap[3], exp_gap(v, 3));
		end
		// Unread bytes overspill; first byte (all ones) stays frozen
		acc(SEL_PRIMARY, 1'b0, 8'h00);
		wait_flag(8'h18);
		chk8(rd & 8'h19, 8'h18);
		enc_bit <= 1'b0;
		repeat (1100) @(posedge sys_clk);
		acc(SEL_DATA, 1'b1, 8'h00);
		chk8(rd, 8'hff);
		wait_flag(8'h01);
		chk8({7'h0, irq_oe}, 8'h01);
		acc(SEL_DATA, 1'b1, 8'h00);
		chk8(rd, 8'h00);
		acc(SEL_PRIMARY, 1'b1, 8'h00);
		chk8(rd & 8'h01, 8'h00);
		acc(SEL_PRIMARY, 1'b0, 8'h01);
		for (i = 0; i < 2; i++) begin
			wait_flag(8'h01);
			acc(SEL_DATA, 1'b1, 8'h00);
		end
		chk8(rd ^ {rd[0], rd[7:1]}, 8'hff);
		acc(SEL_PRIMARY, 1'b0, 8'h00);
		for (i = 0; i < 2; i++) begin
			v = i ? $urandom : 8'h01;
			dec_cap(v);
			chk8(rx[15:8], v);
			chk8(rx[7:0] ^ {rx[0], rx[7:1]}, 8'hff);
		end
		// Loopback: encoder register full of ones feeds the decoder
		enc_bit <= 1'b1;
		acc(SEL_PRIMARY, 1'b0, 8'h02);
		repeat (1100) @(posedge sys_clk);
		dec_cap(8'h00);
		chk8(rx[15:8], 8'h00);
		chk8(rx[7:0], 8'hff);
		acc(SEL_SECONDARY, 1'b1, 8'h00);
		wait_flag(8'h04);
		acc(SEL_SECONDARY, 1'b1, 8'h00);
		chk8(rd, level);
		acc(SEL_PRIMARY, 1'b1, 8'h00);
		chk8(rd & 8'h24, 8'h00);
		// Twenty byte times is well short of one 32-byte page
		repeat (20000) @(posedge sys_clk);
		acc(SEL_PRIMARY, 1'b1, 8'h00);
		chk8(rd & 8'h04, 8'h00);
		// Enable low just after a bit tick: no tick may follow
		@(negedge sys_clk);
		for (k = 0; k < 400 && btk[0] !== 1'b1; k++)
			@(negedge sys_clk);
		if (k == 400) err("encode bit tick never seen");
		@(posedge sys_clk);
		clk_en <= 1'b0;
		repeat (301) @(negedge sys_clk);
		@(posedge sys_clk);
		chk_int(cnt[2], 301);
		chk8({6'h0, irq_n, wt_n}, 8'h00);
		results();
	end
endmodule
`default_nettype wire
